// *** core/uosf_pkg.sv ***
// package for the controller status flag register bank
package uosf_pkg;
    // register map (byte addresses, chosen offsets)
    localparam logic [3:0] STS_OFFSET = 4'h0; // controller_status_flags
    localparam logic [3:0] ENA_OFFSET = 4'h4; // interrupt_enable_mask
    localparam logic [3:0] CTL_OFFSET = 4'h8; // controller_command bits
    // status bit positions
    localparam int BIT_GPT1 = 25;
    localparam int BIT_GPT0 = 24;
    localparam int BIT_PER_DONE = 19;
    localparam int BIT_ASYNC_DONE = 18;
    localparam int BIT_NAK = 16;
    localparam int BIT_ASYNC_ON = 15;
    localparam int BIT_PER_ON = 14;
    localparam int BIT_EMPTY = 13;
    localparam int BIT_HALT = 12;
    localparam int BIT_PHY = 10;
    localparam int BIT_SUSP = 8;
    localparam int BIT_SOF = 7;
    localparam int BIT_RST = 6;
    localparam int BIT_ADVANCE = 5;
    localparam int BIT_BUS_ERR = 4;
    localparam int BIT_WRAP = 3;
    localparam int BIT_PCI = 2;
    localparam int BIT_TXN_ERR = 1;
    localparam int BIT_DONE = 0;
    // write-one-to-clear sticky bits
    localparam logic [31:0] W1C_MASK = 32'h030d_04ff;
    // bits that exist (everything else reserved, reads zero)
    localparam logic [31:0] IMPL_MASK = 32'h030d_f5ff;
    // bits that only have meaning in host mode
    localparam logic [31:0] HOST_ONLY_MASK = 32'h000c_f028;
    // bits that only have meaning in device mode
    localparam logic [31:0] DEV_ONLY_MASK = 32'h0000_0140;
    // command register fields
    localparam int CMD_RUN = 0;
    localparam int CMD_PER_EN = 4;
    localparam int CMD_ASYNC_EN = 5;
    localparam int CMD_DOORBELL = 6;
    localparam logic [31:0] CMD_MASK = 32'h0000_0071;
    localparam logic [31:0] STS_RESET = 32'h0000_1000;
    localparam logic [31:0] ZERO32 = 32'h0000_0000;
    // schedule enable follow delay
    localparam int SCHED_DELAY_NS = 16;
    localparam int CLK_PERIOD_NS = 8;
    localparam int SCHED_DELAY_CYC = (SCHED_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // hardware event strobes, one-cycle pulses
    typedef struct packed {
        logic gpt1_zero;
        logic gpt0_zero;
        logic per_ioc_done;
        logic per_short;
        logic async_ioc_done;
        logic async_short;
        logic phy_access_done;
        logic microframe_tick;
        logic sof_seen;
        logic bus_reset;
        logic async_advanced;
        logic sys_bus_error;
        logic frame_wrap;
        logic port_change;
        logic dev_operational;
        logic txn_error;
        logic txn_ioc;
        logic short_packet;
    } uosf_evt_s;

    // hardware levels
    typedef struct packed {
        logic host_mode;
        logic phy_clk_run;
        logic port_suspended;
        logic dev_suspended;
        logic async_empty;
        logic sched_stopped;
        logic [7:0] ep_nak;
        logic [7:0] ep_nak_en;
    } uosf_lvl_s;
endpackage : uosf_pkg

// *** core/uosf_status_flags.sv ***
// controller status flag register with wishbone slave
//
// What this block does
// - writing one clears a clearable flag
// - timer zero sets bits 25 and 24
// - host periodic completion sets bit 19
// - host async completion sets bit 18
// - endpoint nak flag, cleared by hardware
// - bit 15 shows async schedule state
// - bit 14 shows periodic schedule state
// - bit 13 shows async schedule empty
// - bit 12 shows host halted
// - phy link access done sets bit 10
// - bit 8 follows device suspend
// - host microframe tick sets bit 7 while the phy runs and the port is awake
// - device frame start sets bit 7
// - device bus reset sets bit 6
// - async advance after doorbell sets bit 5
// - system bus error sets 4, stops host
// - frame index wrap sets bit 3
// - host port change sets bit 2
// - device operational entry sets bit 2
// - transaction error sets bit 1
// - completion or short packet sets bit 0
// - reserved bits read as zero
// - interrupt when flag and enable set
`timescale 1ns/1ns
module uosf_status_flags
    import uosf_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    input wire uosf_evt_s evt_i,
    input wire uosf_lvl_s lvl_i,
    output logic irq_o,
    output logic run_stop_o
);
    logic [31:0] sts_r; // stored flags
    logic [31:0] sts_nxt;
    logic [31:0] ena_r; // interrupt enable mask
    logic [31:0] ena_nxt;
    logic [31:0] cmd_r; // run, schedule enables, doorbell
    logic [31:0] cmd_nxt;
    logic [1:0] async_cnt_r; // async enable follow counter
    logic [1:0] async_cnt_nxt;
    logic [1:0] per_cnt_r; // periodic enable follow counter
    logic [1:0] per_cnt_nxt;
    logic [31:0] rdat_nxt;
    logic ack_nxt;
    logic err_nxt;
    logic irq_nxt;
    logic wr_go; // write taken this cycle
    logic [31:0] wmask; // byte-lane expanded write data
    logic [31:0] set_vec; // hardware set requests
    logic [31:0] view; // software-visible status
    logic nak_any;

    // all checks sample on the core clock and sleep while reset is low
    default clocking cb_core @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);

    // one access per request; ack drops in the cycle after it was given
    assign wr_go = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && !wb_err_o;
    always_comb
    begin
        wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}} & wb_dat_i;
    end

    // endpoint nak requests, any enabled pair
    assign nak_any = |(lvl_i.ep_nak & lvl_i.ep_nak_en);

    // collect hardware set events
    always_comb
    begin
        set_vec = ZERO32;
        set_vec[BIT_GPT1] = evt_i.gpt1_zero;
        set_vec[BIT_GPT0] = evt_i.gpt0_zero;
        set_vec[BIT_PER_DONE] = evt_i.per_ioc_done || evt_i.per_short;
        set_vec[BIT_ASYNC_DONE] = evt_i.async_ioc_done || evt_i.async_short;
        set_vec[BIT_PHY] = evt_i.phy_access_done;
        if (lvl_i.host_mode)
        begin
            // tick only while the phy runs and the port is awake
            set_vec[BIT_SOF] = evt_i.microframe_tick && lvl_i.phy_clk_run && !lvl_i.port_suspended;
            set_vec[BIT_PCI] = evt_i.port_change;
        end
        else
        begin
            set_vec[BIT_SOF] = evt_i.sof_seen;
            set_vec[BIT_PCI] = evt_i.dev_operational;
        end
        set_vec[BIT_RST] = evt_i.bus_reset;
        // doorbell must be rung before an advance counts
        set_vec[BIT_ADVANCE] = evt_i.async_advanced && cmd_r[CMD_DOORBELL];
        set_vec[BIT_BUS_ERR] = evt_i.sys_bus_error;
        set_vec[BIT_WRAP] = evt_i.frame_wrap;
        set_vec[BIT_TXN_ERR] = evt_i.txn_error;
        // an erroring descriptor with ioc raises both together
        set_vec[BIT_DONE] = evt_i.txn_ioc || evt_i.short_packet;
    end

    // next status: sticky bits set-wins, level bits follow hardware
    always_comb
    begin
        sts_nxt = sts_r;
        if (wr_go && wb_adr_i == STS_OFFSET)
        begin
            sts_nxt = sts_r & ~(wmask & W1C_MASK);
        end
        sts_nxt = (sts_nxt | set_vec) & W1C_MASK;
        sts_nxt[BIT_NAK] = nak_any;
        sts_nxt[BIT_ASYNC_ON] = (async_cnt_r == 2'(SCHED_DELAY_CYC)) ? cmd_r[CMD_ASYNC_EN]
                                : sts_r[BIT_ASYNC_ON];
        sts_nxt[BIT_PER_ON] = (per_cnt_r == 2'(SCHED_DELAY_CYC)) ? cmd_r[CMD_PER_EN] : sts_r[BIT_PER_ON];
        sts_nxt[BIT_EMPTY] = lvl_i.async_empty;
        // halted clears one cycle after run is set, sets once engines stop
        sts_nxt[BIT_HALT] = !cmd_r[CMD_RUN] && lvl_i.sched_stopped;
        sts_nxt[BIT_SUSP] = lvl_i.dev_suspended;
    end

    // schedule enable follow delay: counters restart on each change
    always_comb
    begin
        async_cnt_nxt = (cmd_r[CMD_ASYNC_EN] != sts_r[BIT_ASYNC_ON]) ? async_cnt_r + 2'h1 : 2'h0;
        per_cnt_nxt = (cmd_r[CMD_PER_EN] != sts_r[BIT_PER_ON]) ? per_cnt_r + 2'h1 : 2'h0;
        if (async_cnt_r == 2'(SCHED_DELAY_CYC))
        begin
            async_cnt_nxt = 2'h0;
        end
        if (per_cnt_r == 2'(SCHED_DELAY_CYC))
        begin
            per_cnt_nxt = 2'h0;
        end
    end

    // mode gating of what software sees
    always_comb
    begin
        if (lvl_i.host_mode)
        begin
            view = sts_r & ~DEV_ONLY_MASK;
        end
        else
        begin
            view = sts_r & ~HOST_ONLY_MASK;
        end
        view = view & IMPL_MASK;
    end

    // command and enable registers
    always_comb
    begin
        cmd_nxt = cmd_r;
        ena_nxt = ena_r;
        if (wr_go && wb_adr_i == CTL_OFFSET)
        begin
            cmd_nxt = ((cmd_r & ~{{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}})
                       | wmask) & CMD_MASK;
        end
        if (wr_go && wb_adr_i == ENA_OFFSET)
        begin
            ena_nxt = ((ena_r & ~{{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}})
                       | wmask) & IMPL_MASK;
        end
        // doorbell self-clears once the advance flag is raised
        if (set_vec[BIT_ADVANCE])
        begin
            cmd_nxt[CMD_DOORBELL] = 1'b0;
        end
        // a system bus error in host mode stops the controller
        if (evt_i.sys_bus_error && lvl_i.host_mode)
        begin
            cmd_nxt[CMD_RUN] = 1'b0;
        end
    end

    // bus answer and interrupt line
    always_comb
    begin
        ack_nxt = 1'b0;
        err_nxt = 1'b0;
        rdat_nxt = ZERO32;
        if (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o)
        begin
            unique case (wb_adr_i)
                STS_OFFSET: rdat_nxt = view;
                ENA_OFFSET: rdat_nxt = ena_r;
                CTL_OFFSET: rdat_nxt = cmd_r;
                default: rdat_nxt = ZERO32;
            endcase
            // unmapped addresses get an error instead of ack
            if (wb_adr_i == STS_OFFSET || wb_adr_i == ENA_OFFSET || wb_adr_i == CTL_OFFSET)
            begin
                ack_nxt = 1'b1;
            end
            else
            begin
                err_nxt = 1'b1;
            end
        end
        // flags record regardless; the mask only gates the line
        irq_nxt = |(view & ena_r);
    end

    // registers
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sts_r <= STS_RESET;
            ena_r <= ZERO32;
            cmd_r <= ZERO32;
            async_cnt_r <= 2'h0;
            per_cnt_r <= 2'h0;
            wb_dat_o <= ZERO32;
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            irq_o <= 1'b0;
            run_stop_o <= 1'b0;
        end
        else
        begin
            sts_r <= sts_nxt;
            ena_r <= ena_nxt;
            cmd_r <= cmd_nxt;
            async_cnt_r <= async_cnt_nxt;
            per_cnt_r <= per_cnt_nxt;
            wb_dat_o <= rdat_nxt;
            wb_ack_o <= ack_nxt;
            wb_err_o <= err_nxt;
            irq_o <= irq_nxt;
            run_stop_o <= cmd_nxt[CMD_RUN];
        end
    end

    // sequences for multi-step checks
    sequence s_clear_write;
        wr_go && wb_adr_i == STS_OFFSET && wb_sel_i[0] && wb_dat_i[BIT_DONE];
    endsequence
    sequence s_no_done_event;
        !set_vec[BIT_DONE];
    endsequence

    // a write of one clears the completion flag when no event races it
    chk_done_w1c: assert property (@(posedge core_clk) disable iff (!rst_b)
        s_clear_write and s_no_done_event |=> !sts_r[BIT_DONE])
        else $error("completion flag not cleared by write one");

    // timer 1 reaching zero raises its flag
    chk_gpt_set: assert property (@(posedge core_clk) disable iff (!rst_b)
        evt_i.gpt1_zero |=> sts_r[BIT_GPT1])
        else $error("timer 1 flag not set");

    // a status read in device mode never shows the host completion flags
    chk_dev_host_zero: assert property (@(posedge core_clk) disable iff (!rst_b)
        !lvl_i.host_mode && wb_cyc_i && wb_stb_i && !wb_ack_o && wb_adr_i == STS_OFFSET
        |=> wb_ack_o && wb_dat_o[BIT_PER_DONE] == 1'b0 && wb_dat_o[BIT_ASYNC_DONE] == 1'b0)
        else $error("host flags visible in device mode");

    // checked one edge on so that levels held during reset cannot trip it
    chk_nak_follow: assert property (@(posedge core_clk) disable iff (!rst_b)
        1'b1 |=> sts_r[BIT_NAK] == $past(nak_any))
        else $error("nak flag does not follow endpoints");

    // a running controller stops reporting itself halted one cycle after run is seen
    chk_halt_run: assert property (@(posedge core_clk) disable iff (!rst_b)
        cmd_r[CMD_RUN] |=> !sts_r[BIT_HALT])
        else $error("halted while running");

    // an event in the cycle of its own clear must survive
    chk_set_wins: assert property (@(posedge core_clk) disable iff (!rst_b)
        s_clear_write and set_vec[BIT_DONE] |=> sts_r[BIT_DONE])
        else $error("clear beat a set");

    // run bit and its pin copy both drop on the edge after the error
    chk_sei_stop: assert property (@(posedge core_clk) disable iff (!rst_b)
        evt_i.sys_bus_error && lvl_i.host_mode |=> !cmd_r[CMD_RUN] && !run_stop_o)
        else $error("bus error did not stop host");

    // the line is a registered and of visible flags and enables
    chk_irq_gate: assert property (@(posedge core_clk) disable iff (!rst_b)
        irq_o == $past(|(view & ena_r)))
        else $error("interrupt line mismatch");

    // the async status catches up with its enable within a few cycles
    chk_async_follow: assert property (@(posedge core_clk) disable iff (!rst_b)
        $rose(cmd_r[CMD_ASYNC_EN]) |-> ##[1:4] sts_r[BIT_ASYNC_ON])
        else $error("async status did not follow enable");

    // timer 0 reaching zero raises its flag
    chk_gpt0_set: assert property (
        evt_i.gpt0_zero |=> sts_r[BIT_GPT0])
        else $error("timer 0 flag not set");

    // periodic completion or short packet raises the periodic flag
    chk_per_done_set: assert property (
        evt_i.per_ioc_done || evt_i.per_short |=> sts_r[BIT_PER_DONE])
        else $error("periodic completion flag not set");

    // async completion or short packet raises the async flag
    chk_async_done_set: assert property (
        evt_i.async_ioc_done || evt_i.async_short |=> sts_r[BIT_ASYNC_DONE])
        else $error("async completion flag not set");

    // the periodic status catches up with its enable within a few cycles
    chk_per_follow: assert property (
        $rose(cmd_r[CMD_PER_EN]) |-> ##[1:4] sts_r[BIT_PER_ON])
        else $error("periodic status did not follow enable");

    // the empty bit is the async empty level one cycle late
    chk_empty_follow: assert property (
        1'b1 |=> sts_r[BIT_EMPTY] == $past(lvl_i.async_empty))
        else $error("empty bit does not follow schedule");

    // a finished phy link access raises its flag
    chk_phy_set: assert property (
        evt_i.phy_access_done |=> sts_r[BIT_PHY])
        else $error("phy access flag not set");

    // the suspend bit is the device suspend level one cycle late
    chk_susp_follow: assert property (
        1'b1 |=> sts_r[BIT_SUSP] == $past(lvl_i.dev_suspended))
        else $error("suspend bit does not follow level");

    // host tick counts only with the phy running and the port awake
    chk_host_tick: assert property (
        lvl_i.host_mode && evt_i.microframe_tick && lvl_i.phy_clk_run && !lvl_i.port_suspended |=> sts_r[BIT_SOF])
        else $error("host tick did not set frame flag");

    // a frame start seen by the device raises the frame flag
    chk_dev_sof: assert property (
        !lvl_i.host_mode && evt_i.sof_seen |=> sts_r[BIT_SOF])
        else $error("device frame start did not set flag");

    // a detected bus reset raises its flag
    chk_bus_reset: assert property (
        evt_i.bus_reset |=> sts_r[BIT_RST])
        else $error("bus reset flag not set");

    // an advance after the doorbell sets the flag and spends the doorbell
    chk_advance_set: assert property (
        evt_i.async_advanced && cmd_r[CMD_DOORBELL] |=> sts_r[BIT_ADVANCE] && !cmd_r[CMD_DOORBELL])
        else $error("async advance not flagged");

    // a system bus error raises its flag in either mode
    chk_bus_err_set: assert property (
        evt_i.sys_bus_error |=> sts_r[BIT_BUS_ERR])
        else $error("system bus error flag not set");

    // a frame index wrap raises its flag
    chk_wrap_set: assert property (
        evt_i.frame_wrap |=> sts_r[BIT_WRAP])
        else $error("frame wrap flag not set");

    // a host port change raises the port flag
    chk_pci_host: assert property (
        lvl_i.host_mode && evt_i.port_change |=> sts_r[BIT_PCI])
        else $error("host port change not flagged");

    // device entry to the operational state raises the port flag
    chk_pci_dev: assert property (
        !lvl_i.host_mode && evt_i.dev_operational |=> sts_r[BIT_PCI])
        else $error("device operational entry not flagged");

    // a failed transaction raises the error flag
    chk_txn_err_set: assert property (
        evt_i.txn_error |=> sts_r[BIT_TXN_ERR])
        else $error("transaction error flag not set");

    // a completion with ioc or a short packet raises the completion flag
    chk_done_set: assert property (
        evt_i.txn_ioc || evt_i.short_packet |=> sts_r[BIT_DONE])
        else $error("completion flag not set");

    // any answered read keeps the reserved bits at zero
    chk_reserved_zero: assert property (
        wb_ack_o |-> (wb_dat_o & ~IMPL_MASK) == ZERO32)
        else $error("reserved bits read as one");

    // a zero in the write data leaves a set flag alone
    chk_zero_write: assert property (
        wr_go && wb_adr_i == STS_OFFSET && !wmask[BIT_GPT1] && sts_r[BIT_GPT1] |=> sts_r[BIT_GPT1])
        else $error("zero write cleared a flag");
endmodule : uosf_status_flags

// *** verification/uosf_status_flags_tb_top.sv ***
// self-checking bench for the controller status flag register bank
`timescale 1ns/1ns
module uosf_status_flags_tb_top
    import uosf_pkg::*;
();
    logic core_clk = 1'b0; // 8 ns period
    logic rst_b = 1'b0; // held low for 6 cycles
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [3:0] wb_adr_i = 4'h0;
    logic [3:0] wb_sel_i = 4'hf; // whole-word accesses only
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic wb_err_o;
    logic irq_o;
    logic run_stop_o;
    uosf_evt_s evt_i = '0; // event strobes, one cycle each
    uosf_lvl_s lvl_i = '0; // level inputs
    int num_errors = 0;
    int samples_checked = 0;
    int cycles = 0; // hang guard
    logic [31:0] rd; // data of the last access
    logic er; // error answer of the last access
    uosf_evt_s ev; // event pattern under test
    logic [31:0] base; // level bits expected in the status word

    uosf_status_flags i_dut
    (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o),
        .wb_err_o(wb_err_o),
        .evt_i(evt_i),
        .lvl_i(lvl_i),
        .irq_o(irq_o),
        .run_stop_o(run_stop_o)
    );

    // free-running clock
    always #4 core_clk = ~core_clk;

    // the whole run needs under 2000 cycles, so 5000 means a hang
    always @(posedge core_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            num_errors++;
            results();
        end
    end

    // compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // one classic cycle; e pulses on the edge that takes the request
    task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] dat, input uosf_evt_s e);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        evt_i <= e;
        @(posedge core_clk);
        evt_i <= '0;
        // hold the request until the slave answers
        do
            @(posedge core_clk);
        while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
        rd = wb_dat_o;
        er = wb_err_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        // bus idles one cycle between requests
        @(posedge core_clk);
    endtask : wb

    // random events; async advance needs the doorbell, so it is kept out
    function automatic uosf_evt_s draw();
        logic [31:0] r;
        uosf_evt_s e;
        r = $urandom;
        e = r[17:0];
        e.async_advanced = 1'b0;
        // a schedule completion or short packet is also a plain one
        e.txn_ioc = e.txn_ioc | e.per_ioc_done | e.async_ioc_done;
        e.short_packet = e.short_packet | e.per_short | e.async_short;
        return e;
    endfunction : draw

    // status bits that an event pattern must set in each mode
    function automatic logic [31:0] evt_bits(input uosf_evt_s e, input logic host);
        logic [31:0] m;
        m = 32'h0000_0000;
        m[BIT_GPT1] = e.gpt1_zero;
        m[BIT_GPT0] = e.gpt0_zero;
        m[BIT_PHY] = e.phy_access_done;
        m[BIT_BUS_ERR] = e.sys_bus_error;
        m[BIT_TXN_ERR] = e.txn_error;
        m[BIT_DONE] = e.txn_ioc | e.short_packet;
        if (host)
        begin
            m[BIT_PER_DONE] = e.per_ioc_done | e.per_short;
            m[BIT_ASYNC_DONE] = e.async_ioc_done | e.async_short;
            // the tick only counts while the phy runs and the port is awake
            m[BIT_SOF] = e.microframe_tick & lvl_i.phy_clk_run & ~lvl_i.port_suspended;
            m[BIT_WRAP] = e.frame_wrap;
            m[BIT_PCI] = e.port_change;
        end
        else
        begin
            m[BIT_SOF] = e.sof_seen;
            m[BIT_RST] = e.bus_reset;
            m[BIT_PCI] = e.dev_operational;
        end
        return m;
    endfunction : evt_bits

    // verdict, the only exit of the run
    task automatic results();
        $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : results

    // main sequence
    initial
    begin
        void'($urandom(32'h6c55027a));
        lvl_i.host_mode = 1'b1;
        lvl_i.phy_clk_run = 1'b1;
        lvl_i.sched_stopped = 1'b1;
        repeat (6) @(posedge core_clk);
        rst_b <= 1'b1;
        wb(1'b0, STS_OFFSET, ZERO32, '0);
        check(rd, STS_RESET);
        // unmapped address is refused
        wb(1'b0, 4'hc, ZERO32, '0);
        check({31'h0, er}, 32'h0000_0001);
        // host pass first, then device pass
        for (int m = 0; m < 2; m++)
        begin
            lvl_i.host_mode <= (m == 0);
            repeat (2) @(posedge core_clk);
            base = (m == 0) ? STS_RESET : ZERO32;
            wb(1'b1, STS_OFFSET, IMPL_MASK, '0);
            for (int i = 0; i < 24; i++)
            begin
                ev = draw();
                lvl_i.port_suspended <= 1'($urandom_range(1));
                lvl_i.phy_clk_run <= 1'($urandom_range(1));
                // events land in the same cycle as a full clear; reserved bits stay zero
                wb(1'b1, STS_OFFSET, IMPL_MASK, ev);
                wb(1'b0, STS_OFFSET, ZERO32, '0);
                check(rd, base | evt_bits(ev, m == 0));
                wb(1'b1, STS_OFFSET, ZERO32, '0);
                wb(1'b0, STS_OFFSET, ZERO32, '0);
                check(rd, base | evt_bits(ev, m == 0));
                wb(1'b1, STS_OFFSET, IMPL_MASK, '0);
                wb(1'b0, STS_OFFSET, ZERO32, '0);
                check(rd, base);
            end
        end
        // device levels: suspend and an enabled endpoint nak
        lvl_i.dev_suspended <= 1'b1;
        lvl_i.async_empty <= 1'b1;
        lvl_i.ep_nak <= 8'h24;
        lvl_i.ep_nak_en <= 8'h04;
        repeat (2) @(posedge core_clk);
        wb(1'b0, STS_OFFSET, ZERO32, '0);
        check(rd, 32'h0001_0100);
        lvl_i.dev_suspended <= 1'b0;
        lvl_i.ep_nak <= 8'h20; // only a masked endpoint still naks
        repeat (2) @(posedge core_clk);
        wb(1'b0, STS_OFFSET, ZERO32, '0);
        check(rd, ZERO32);
        // host: run with both schedules and ring the doorbell
        lvl_i.host_mode <= 1'b1;
        repeat (2) @(posedge core_clk);
        wb(1'b1, ENA_OFFSET, 32'h0000_0020, '0);
        wb(1'b1, CTL_OFFSET, 32'h0000_0071, '0);
        check({31'h0, run_stop_o}, 32'h0000_0001);
        repeat (4) @(posedge core_clk);
        ev = '0;
        ev.async_advanced = 1'b1;
        wb(1'b0, ENA_OFFSET, ZERO32, ev);
        wb(1'b0, STS_OFFSET, ZERO32, '0);
        check(rd, 32'h0000_e020);
        check({31'h0, irq_o}, 32'h0000_0001);
        // doorbell is spent, so a further advance must not set the flag
        wb(1'b1, STS_OFFSET, 32'h0000_0020, ev);
        wb(1'b0, STS_OFFSET, ZERO32, '0);
        check(rd, 32'h0000_e000);
        check({31'h0, irq_o}, ZERO32);
        // system bus error stops the host; its enable is off
        ev = '0;
        ev.sys_bus_error = 1'b1;
        wb(1'b0, ENA_OFFSET, ZERO32, ev);
        repeat (2) @(posedge core_clk);
        wb(1'b0, STS_OFFSET, ZERO32, '0);
        check(rd, 32'h0000_f010);
        check({30'h0, run_stop_o, irq_o}, ZERO32);
        results();
    end
endmodule : uosf_status_flags_tb_top
